/* File: logic/line_ais_params.svh */
// Register indices, field positions, reset values for line AIS control
`ifndef LINE_AIS_PARAMS_SVH
`define LINE_AIS_PARAMS_SVH
// Register indices; byte address is four times the index
`define LAC_CTRL_IDX 8'h11
`define LAC_EN_IDX 8'h20
`define LAC_STAT_IDX 8'h21
`define LAC_MASK_IDX 8'h22
// line_ais_control fields
`define LAC_CLK_INV 0
`define LAC_FORCE 1
`define LAC_AEN 2
`define LAC_PINSEL 3
// Alarm enable register fields
`define LAC_EN_LABEL 0
`define LAC_EN_LOCK 1
`define LAC_EN_TIM 2
`define LAC_EN_BSAIS 3
`define LAC_EN_LOF 4
// Status and mask fields
`define LAC_ST_RISE 0
`define LAC_ST_FALL 1
// Reset values
`define LAC_CTRL_RST 4'h0
`define LAC_EN_RST 5'h00
`define LAC_STAT_RST 2'h0
`define LAC_MASK_RST 2'h0
// Majority threshold over the 8 overhead bits
`define LAC_MAJ 4'h5
// Bus answers
`define LAC_RESP_OK 2'h0
`define LAC_RESP_ERR 2'h2
`endif

/* File: logic/line_ais_pkg.sv */
// Types shared by the line AIS control block
package line_ais_pkg;
   localparam int LINE_W = 8;
   typedef logic [LINE_W-1:0] line_data_t;
   typedef logic [7:0] reg_idx_t;
   // Whole state of the block
   typedef struct packed {
      logic [3:0] ctrl;
      logic [4:0] en;
      logic [1:0] status;
      logic [1:0] mask;
      logic aw_ok;
      reg_idx_t aw_idx;
      logic w_ok;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic e1_ais;
      logic ais;
      logic clk;
      line_data_t data;
   } lac_state_s;
endpackage

/* File: logic/receive_line_ais_control.sv */
// Receive line AIS control with AXI4-Lite registers
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "line_ais_params.svh"
module receive_line_ais_control #(
   parameter int ADDR_W = 12
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic upstream_status_in_i,
   input wire logic upstream_path_alarm_in_i,
   input wire logic ext_ais_in_n_i,
   input wire logic [7:0] e1_byte_i,
   input wire logic e1_byte_valid_i,
   input wire logic pointer_tracking_pin_i,
   input wire logic drop_bus_trace_loss_i,
   input wire logic drop_bus_clock_loss_i,
   input wire logic signal_label_mismatch_i,
   input wire logic signal_label_unequipped_i,
   input wire logic trace_lock_loss_i,
   input wire logic trace_message_mismatch_i,
   input wire logic pointer_loss_i,
   input wire logic pointer_path_ais_i,
   input wire logic line_frame_alignment_loss_i,
   input wire line_ais_pkg::line_data_t line_data_i,
   output line_ais_pkg::line_data_t line_data_o,
   output logic receive_line_clock_out_o,
   output logic line_ais_ind_o,
   output logic irq_o
);
   import line_ais_pkg::*;

   lac_state_s s_q;
   lac_state_s s_d;
   logic ais_d;
   logic aen;
   logic pinsel;
   logic bsais;
   logic launch;
   logic [1:0] ev;

   // Count of ones in the overhead byte
   function automatic logic [3:0] ones8(input logic [7:0] b);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++) begin
         n = n + {3'h0, b[i]};
      end
      return n;
   endfunction

   // Register index from a byte address; word aligned
   function automatic reg_idx_t idx_of(input logic [ADDR_W-1:0] a);
      return a[9:2];
   endfunction

   // Read value and answer for one index
   function automatic logic [33:0] rd_val(input reg_idx_t i, input lac_state_s s);
      logic [33:0] r;
      r = {`LAC_RESP_OK, 32'h0000_0000};
      unique case (i)
         `LAC_CTRL_IDX: r[3:0] = s.ctrl;
         `LAC_EN_IDX: r[4:0] = s.en;
         `LAC_STAT_IDX: r[1:0] = s.status;
         `LAC_MASK_IDX: r[1:0] = s.mask;
         default: r[33:32] = `LAC_RESP_ERR;
      endcase
      return r;
   endfunction

   assign aen = s_q.ctrl[`LAC_AEN];
   assign pinsel = s_q.ctrl[`LAC_PINSEL];
   assign bsais = s_q.en[`LAC_EN_BSAIS];
   // Clock output is about to change toward the chosen launch edge
   assign launch = s_q.clk ^ s_q.ctrl[`LAC_CLK_INV];

   // Line AIS decision; inputs taken as synchronous
   always_comb begin
      logic alarm;
      alarm = 1'b0;
      alarm = alarm | ~ext_ais_in_n_i;
      alarm = alarm | (~pinsel & s_q.e1_ais);
      alarm = alarm | (pinsel & (upstream_status_in_i | upstream_path_alarm_in_i));
      if (pointer_tracking_pin_i) begin
         alarm = alarm | pointer_loss_i | pointer_path_ais_i;
      end else begin
         alarm = alarm | drop_bus_trace_loss_i;
      end
      alarm = alarm | (~bsais & drop_bus_clock_loss_i);
      alarm = alarm | (s_q.en[`LAC_EN_LABEL]
                       & (signal_label_mismatch_i | signal_label_unequipped_i));
      alarm = alarm | (s_q.en[`LAC_EN_LOCK] & trace_lock_loss_i);
      alarm = alarm | (s_q.en[`LAC_EN_TIM] & trace_message_mismatch_i);
      // Frame loss path sits outside the alarm-driven enable
      ais_d = (aen & alarm)
              | s_q.ctrl[`LAC_FORCE]
              | (s_q.en[`LAC_EN_LOF] & ~bsais & line_frame_alignment_loss_i);
   end

   // Events for the status register
   assign ev[`LAC_ST_RISE] = ais_d & ~s_q.ais;
   assign ev[`LAC_ST_FALL] = ~ais_d & s_q.ais;

   // Next state: bus slave, registers, line output
   always_comb begin
      logic [1:0] clr;
      logic [33:0] rv;
      s_d = s_q;
      clr = 2'h0;
      rv = rd_val(idx_of(s_axi_araddr_i), s_q);
      // Write address and data taken in either order
      if (s_axi_awvalid_i && s_axi_awready_o) begin
         s_d.aw_ok = 1'b1;
         s_d.aw_idx = idx_of(s_axi_awaddr_i);
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
         s_d.w_ok = 1'b1;
         s_d.wdata = s_axi_wdata_i;
         s_d.wstrb = s_axi_wstrb_i;
      end
      // Both halves held: commit and answer; only byte lane 0 carries fields
      if (s_q.aw_ok && s_q.w_ok) begin
         s_d.aw_ok = 1'b0;
         s_d.w_ok = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = `LAC_RESP_OK;
         unique case (s_q.aw_idx)
            `LAC_CTRL_IDX: if (s_q.wstrb[0]) s_d.ctrl = s_q.wdata[3:0];
            `LAC_EN_IDX: if (s_q.wstrb[0]) s_d.en = s_q.wdata[4:0];
            `LAC_STAT_IDX: if (s_q.wstrb[0]) clr = s_q.wdata[1:0];
            `LAC_MASK_IDX: if (s_q.wstrb[0]) s_d.mask = s_q.wdata[1:0];
            default: s_d.bresp = `LAC_RESP_ERR;
         endcase
      end else if (s_q.bvalid && s_axi_bready_i) begin
         s_d.bvalid = 1'b0;
      end
      // Read answered one cycle after address taken
      if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = rv[31:0];
         s_d.rresp = rv[33:32];
      end else if (s_q.rvalid && s_axi_rready_i) begin
         s_d.rvalid = 1'b0;
      end
      // Set wins over a clear in the same cycle
      s_d.status = (s_q.status & ~clr) | ev;
      // Overhead AIS flag held until the next overhead byte
      if (e1_byte_valid_i) begin
         s_d.e1_ais = ones8(e1_byte_i) >= `LAC_MAJ;
      end
      s_d.ais = ais_d;
      // Line clock runs at half rate whatever the alarm state
      s_d.clk = ~s_q.clk;
      if (launch) begin
         s_d.data = s_q.ais ? '1 : line_data_i;
      end
   end

   // State register
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.ctrl <= `LAC_CTRL_RST;
         s_q.en <= `LAC_EN_RST;
         s_q.status <= `LAC_STAT_RST;
         s_q.mask <= `LAC_MASK_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Ports; ready terms stall while an answer is pending
   assign s_axi_awready_o = ~s_q.aw_ok & ~s_q.bvalid;
   assign s_axi_wready_o = ~s_q.w_ok & ~s_q.bvalid;
   assign s_axi_bvalid_o = s_q.bvalid;
   assign s_axi_bresp_o = s_q.bresp;
   assign s_axi_arready_o = ~s_q.rvalid;
   assign s_axi_rvalid_o = s_q.rvalid;
   assign s_axi_rdata_o = s_q.rdata;
   assign s_axi_rresp_o = s_q.rresp;
   assign line_data_o = s_q.data;
   assign receive_line_clock_out_o = s_q.clk;
   assign line_ais_ind_o = s_q.ais;
   assign irq_o = |(s_q.status & s_q.mask);

   // Checks next to the logic they guard
   AST_FORCE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      s_q.ctrl[`LAC_FORCE] |=> line_ais_ind_o)
      else $error("force bit did not raise line AIS");
   AST_EXT_N: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      aen && !ext_ais_in_n_i |=> line_ais_ind_o)
      else $error("external AIS input ignored");
   AST_PINSEL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      aen && pinsel && upstream_path_alarm_in_i |=> line_ais_ind_o)
      else $error("selected upstream pin ignored");
   AST_MAJORITY: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      e1_byte_valid_i |=> s_q.e1_ais == (ones8($past(e1_byte_i)) > 4'h4))
      else $error("overhead majority vote wrong");
   AST_QUIET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !aen && !s_q.ctrl[`LAC_FORCE] && !line_frame_alignment_loss_i |=> !line_ais_ind_o)
      else $error("line AIS without an enabled cause");
   AST_POINTER: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      aen && pointer_tracking_pin_i && pointer_path_ais_i |=> line_ais_ind_o)
      else $error("pointer path AIS ignored");
   AST_CLK_LOSS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      aen && !bsais && drop_bus_clock_loss_i |=> line_ais_ind_o)
      else $error("drop bus clock loss ignored");
   AST_LABEL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      aen && s_q.en[`LAC_EN_LABEL] && signal_label_unequipped_i |=> line_ais_ind_o)
      else $error("unequipped label ignored");
   AST_TRACE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      aen && s_q.en[`LAC_EN_TIM] && trace_message_mismatch_i |=> line_ais_ind_o)
      else $error("trace mismatch ignored");
   AST_FRAME: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      s_q.en[`LAC_EN_LOF] && !bsais && line_frame_alignment_loss_i |=> line_ais_ind_o)
      else $error("frame loss ignored");
   AST_EDGE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !$stable(line_data_o) |-> ($fell(receive_line_clock_out_o) && !$past(s_q.ctrl[`LAC_CLK_INV]))
                              || ($rose(receive_line_clock_out_o) && $past(s_q.ctrl[`LAC_CLK_INV])))
      else $error("data launched on wrong clock edge");
   AST_ONES: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      line_ais_ind_o && launch |=> line_data_o == '1 ##1 $changed(receive_line_clock_out_o))
      else $error("AIS data not all ones or clock stopped");

   // Remaining alarm causes, one input each
   AST_TRACE_LOSS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      aen && !pointer_tracking_pin_i && drop_bus_trace_loss_i |=> line_ais_ind_o)
      else $error("drop bus trace loss ignored");
   AST_PTR_LOSS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      aen && pointer_tracking_pin_i && pointer_loss_i |=> line_ais_ind_o)
      else $error("pointer loss ignored");
   AST_UP_STATUS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      aen && pinsel && upstream_status_in_i |=> line_ais_ind_o)
      else $error("selected upstream status pin ignored");
   AST_INBAND: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      aen && !pinsel && s_q.e1_ais |=> line_ais_ind_o)
      else $error("overhead byte AIS ignored");
   AST_MISMATCH: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      aen && s_q.en[`LAC_EN_LABEL] && signal_label_mismatch_i |=> line_ais_ind_o)
      else $error("label mismatch ignored");
   AST_LOCK: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      aen && s_q.en[`LAC_EN_LOCK] && trace_lock_loss_i |=> line_ais_ind_o)
      else $error("trace lock loss ignored");

   // Line output: clock never stops, clean data passes untouched
   AST_CLK_RUN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      1'b1 |=> $changed(receive_line_clock_out_o))
      else $error("line clock stopped");
   AST_PASS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !line_ais_ind_o && launch |=> line_data_o == $past(line_data_i))
      else $error("line data not passed through");

   // Bus answers stand until taken; a read of the control index returns the control register
   AST_B_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write answer dropped before taken");
   AST_R_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read answer dropped before taken");
   AST_RD_CTRL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      s_axi_arvalid_i && s_axi_arready_o && idx_of(s_axi_araddr_i) == `LAC_CTRL_IDX
      |=> s_axi_rdata_o == {28'h0, $past(s_q.ctrl)})
      else $error("control read value wrong");

   // Status flags: an event always lands, even against a clear
   AST_SET_RISE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ev[`LAC_ST_RISE] |=> s_q.status[`LAC_ST_RISE])
      else $error("AIS start event lost");
   AST_SET_FALL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ev[`LAC_ST_FALL] |=> s_q.status[`LAC_ST_FALL])
      else $error("AIS end event lost");
endmodule
`default_nettype wire

/* File: tb/line_sink.sv */
// Downstream line equipment model sampling the receive line data
`timescale 1ns/1ns
`default_nettype none
module line_sink (
   input wire logic clk_i,
   input wire logic inv_i,
   input wire line_ais_pkg::line_data_t data_i,
   output line_ais_pkg::line_data_t data_o
);
   import line_ais_pkg::*;
   line_data_t rise_q;
   line_data_t fall_q;
   // Sample on the edge opposite the launch, mid data eye
   always @(posedge clk_i) rise_q <= data_i;
   always @(negedge clk_i) fall_q <= data_i;
   assign data_o = inv_i ? fall_q : rise_q;
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for receive line AIS control
`timescale 1ns/1ns
`default_nettype none
`include "line_ais_params.svh"
module tb;
   import line_ais_pkg::*;
   logic clk, rst, awv, wv, bry, arv, rry, e1v, prb, inv, awr, wrd, bv, arr, rv, lco, ind, irq;
   logic [11:0] awa, ara;
   logic [31:0] wd, rdat, rs;
   logic [1:0] bresp, rresp;
   logic [12:0] al;
   logic [7:0] e1b;
   line_data_t ld, lo, snk;
   logic [1:0] eb[$];
   logic [33:0] er[$];
   logic [9:0] ep[$];
   int n_errors, checks, cyc;
   // Case packing: ctrl[22:19] enables[18:14] alarm inputs[13:1] expected AIS[0]
   localparam logic [22:0] TBL [23] = '{23'h200002, 23'h600003, 23'h600005, 23'h000008, 23'h200009,
      23'h200011, 23'h202010, 23'h202401, 23'h202801, 23'h200400, 23'h200021, 23'h220020, 23'h200040,
      23'h204041, 23'h204081, 23'h208101, 23'h200100, 23'h210201, 23'h041001, 23'h061000, 23'h180001,
      23'h080000, 23'h000020};
   receive_line_ais_control i_dut (.sys_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
      .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(ara),
      .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .upstream_status_in_i(al[0]), .upstream_path_alarm_in_i(al[1]),
      .ext_ais_in_n_i(!al[2]), .e1_byte_i(e1b), .e1_byte_valid_i(e1v), .pointer_tracking_pin_i(al[12]),
      .drop_bus_trace_loss_i(al[3]), .drop_bus_clock_loss_i(al[4]), .signal_label_mismatch_i(al[5]),
      .signal_label_unequipped_i(al[6]), .trace_lock_loss_i(al[7]), .trace_message_mismatch_i(al[8]),
      .pointer_loss_i(al[9]), .pointer_path_ais_i(al[10]), .line_frame_alignment_loss_i(al[11]),
      .line_data_i(ld), .line_data_o(lo), .receive_line_clock_out_o(lco), .line_ais_ind_o(ind), .irq_o(irq));
   line_sink i_sink (.clk_i(lco), .inv_i(inv), .data_i(lo), .data_o(snk));
   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   task automatic cmp(input string nm, input logic [33:0] e, input logic [33:0] s);
      checks++;
      if (e !== s) begin
         $display("FAIL %s expected %h seen %h", nm, e, s);
         n_errors++;
      end
   endtask
   task automatic summarize();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Write: address and data offered together, each dropped once taken
   task automatic wreg(input logic [7:0] ix, input logic [31:0] d, input logic [1:0] r);
      eb.push_back(r);
      awa <= {2'h0, ix, 2'h0};
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      // No wait limit here; the cycle ceiling ends a hang
      while (!(bv && bry)) begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
      end
      bry <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rreg(input logic [7:0] ix, input logic [33:0] e);
      er.push_back(e);
      ara <= {2'h0, ix, 2'h0};
      arv <= 1'b1;
      rry <= 1'b1;
      while (!(rv && rry)) begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end
      rry <= 1'b0;
      @(posedge clk);
   endtask
   // Settling time covers register effect, AIS update and one line period
   task automatic probe(input logic [9:0] e);
      repeat (8) @(posedge clk);
      ep.push_back(e);
      prb <= 1'b1;
      @(posedge clk);
      prb <= 1'b0;
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = !clk;
   end
   // Each result is matched against the oldest pending note
   always @(posedge clk) begin
      if (bv && bry) cmp("bresp", 34'(eb.pop_front()), 34'(bresp));
      if (rv && rry) cmp("read", er.pop_front(), {rresp, rdat});
      if (prb) cmp("line", 34'(ep.pop_front()), {24'h0, irq, ind, snk});
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         summarize();
      end
   end
   initial begin
      int i;
      logic [22:0] c;
      logic [31:0] r;
      logic [7:0] b;
      {rst, awv, wv, bry, arv, rry, e1v, prb, inv} = 9'h100;
      {awa, ara, wd, al, e1b, ld, n_errors, checks, cyc} = '0;
      rs = 32'h4;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rreg(`LAC_CTRL_IDX, 34'h0);
      rreg(`LAC_EN_IDX, 34'h0);
      r = xs();
      wreg(`LAC_CTRL_IDX, r, `LAC_RESP_OK);
      rreg(`LAC_CTRL_IDX, {30'h0, r[3:0]});
      wreg(8'h30, r, `LAC_RESP_ERR);
      rreg(8'h30, {`LAC_RESP_ERR, 32'h0});
      for (i = 0; i < 23; i++) begin
         c = TBL[i];
         r = xs();
         wreg(`LAC_CTRL_IDX, {28'h0, c[22:19]}, `LAC_RESP_OK);
         wreg(`LAC_EN_IDX, {27'h0, c[18:14]}, `LAC_RESP_OK);
         al <= c[13:1];
         ld <= r[7:0];
         inv <= c[19];
         probe({1'b0, c[0], c[0] ? 8'hff : r[7:0]});
      end
      al <= '0; // Last case left a clock loss standing
      wreg(`LAC_CTRL_IDX, 32'h4, `LAC_RESP_OK);
      for (i = 0; i < 3; i++) begin
         b = (i == 0) ? 8'h1f : ((i == 1) ? 8'h0f : 8'hf8);
         e1b <= b;
         e1v <= 1'b1;
         @(posedge clk);
         e1v <= 1'b0;
         probe({1'b0, $countones(b) >= 5, ($countones(b) >= 5) ? 8'hff : ld});
      end
      wreg(`LAC_CTRL_IDX, 32'h0, `LAC_RESP_OK);
      wreg(`LAC_MASK_IDX, 32'h1, `LAC_RESP_OK);
      wreg(`LAC_CTRL_IDX, 32'h2, `LAC_RESP_OK);
      probe({2'b11, 8'hff});
      wreg(`LAC_STAT_IDX, 32'h3, `LAC_RESP_OK);
      probe({2'b01, 8'hff});
      wreg(`LAC_CTRL_IDX, 32'h0, `LAC_RESP_OK);
      rreg(`LAC_STAT_IDX, 34'h2);
      wreg(`LAC_MASK_IDX, 32'h3, `LAC_RESP_OK);
      probe({2'b10, ld});
      wreg(`LAC_STAT_IDX, 32'h2, `LAC_RESP_OK);
      probe({2'b00, ld});
      summarize();
   end
endmodule
`default_nettype wire
